// File: hw/lcdhi_dev.sv
// Purpose: display controller end: bus width, text ram, address and shift
// Assumes: host obeys the init order; srst models power-on reset
// Notes:   panel drive is not modelled; a read port exposes the ram
`timescale 1ns/1ps
`include "lcdhi_regs.svh"
// Notes on behaviour
// - power-up defaults to full 8-bit bus
// - first write is taken as full byte
// - nibble mode executes after both halves
// - host sends function-set upper half twice
// - host issues function set before display
// - text ram holds 80 character codes
// - shift moves window, never ram contents
// - return home restores window and address
// - two-line: address 39 wraps to line two
// - host reloads address past visible characters
// - both lines shift together, never across
// - host may initialise by instruction sequence
// - after reset data writes hit text ram
// - function set 0010 upper enters nibble mode
module lcdhi_dev
(
  input  wire logic       sys_clk,      // system clock
  input  wire logic       srst,         // synchronous reset, active high
  lcdhi_link_if.dev       link,         // host write bus
  input  wire logic [6:0] rd_addr,      // user ram read address
  output logic      [7:0] rd_char,      // character at rd_addr
  output logic      [6:0] addr_out,     // current ram address
  output logic      [6:0] shift_out,    // display window offset per line
  output logic            two_line_out, // two-line mode flag
  output logic            nibble_out,   // bus is in 4-bit mode
  output logic            exec_pulse    // one cycle when an operation executes
);
  // state; the ram spans the whole 7-bit address so line two at 0x40 needs no remap
  localparam int DEPTH = `LCDHI_RAM_DEPTH;
  logic [7:0] text_ram [0:127];                     // 80 used
  lcdhi_pkg::lcdhi_bus_t bus_reg, bus_next;
  logic [3:0] hi_reg;
  logic [6:0] addr_reg, shift_reg;
  logic       two_line_reg, inc_reg, shift_en_reg, glyph_sel_reg;
  logic [7:0] rd_reg;

  // address step: in two-line mode column 39 runs on into the start of the other line
  function automatic logic [6:0] lcdhi_addr_step(input logic [6:0] a, input logic up, input logic two);
    logic [5:0] col;
    col = a[5:0];
    if (two)
    begin
      if (up && col == 6'(`LCDHI_LINE_LEN - 1))
        return {!a[6], 6'h00};
      if (!up && col == 6'h00)
        return {!a[6], 6'(`LCDHI_LINE_LEN - 1)};
      return up ? {a[6], col + 6'h01} : {a[6], col - 6'h01};
    end
    if (up)
      return (a == 7'(DEPTH - 1)) ? 7'h00 : a + 7'h01;
    return (a == 7'h00) ? 7'(DEPTH - 1) : a - 7'h01;
  endfunction : lcdhi_addr_step

  // window step: one offset for both lines, wrapping on a line's length so nothing crosses lines
  function automatic logic [6:0] lcdhi_win_step(input logic [6:0] s, input logic up, input logic two);
    logic [6:0] last;
    last = two ? 7'(`LCDHI_LINE_LEN - 1) : 7'(DEPTH - 1);
    if (up)
      return (s >= last) ? 7'h00 : s + 7'h01;
    return (s == 7'h00) ? last : s - 7'h01;
  endfunction : lcdhi_win_step

  // assemble a whole byte; first write and 8-bit mode take it at once
  wire       stb       = link.wr_stb;
  wire       rs        = link.instr_data_select;
  wire [3:0] up_n      = link.data_lines[7:4];
  wire       in_nib    = (bus_reg == lcdhi_pkg::LCDHI_BUS_HI) || (bus_reg == lcdhi_pkg::LCDHI_BUS_LO);
  wire       full_now  = stb && !in_nib;
  wire       low_now   = stb && (bus_reg == lcdhi_pkg::LCDHI_BUS_LO);
  wire       exec      = full_now || low_now;
  wire [7:0] byte_in   = low_now ? {hi_reg, up_n} : link.data_lines;
  // instruction decode; display control codes fall through and change no state here
  wire       is_fset   = !rs && (byte_in[7:5] == 3'b001);
  wire       is_home   = !rs && (byte_in[7:1] == 7'h01);
  wire       is_clear  = !rs && (byte_in == `LCDHI_CMD_CLEAR);
  wire       is_entry  = !rs && (byte_in[7:2] == 6'h01);
  wire       is_shift  = !rs && (byte_in[7:4] == 4'h1);
  wire       is_ddaddr = !rs && byte_in[7];
  wire       is_cgaddr = !rs && (byte_in[7:6] == 2'b01);
  wire       to_nib    = is_fset && (byte_in[7:4] == `LCDHI_FSET_NIB4);
  wire       to_8bit   = is_fset && byte_in[4];
  wire       wr_text   = exec && rs && !glyph_sel_reg;
  wire [6:0] next_addr = lcdhi_addr_step(addr_reg, inc_reg, two_line_reg);

  // bus width state
  always_comb
  begin
    bus_next = bus_reg;
    if (stb)
    begin
      // the lone first write lands in INIT and is always taken whole
      unique case (bus_reg)
        lcdhi_pkg::LCDHI_BUS_INIT,
        lcdhi_pkg::LCDHI_BUS_8BIT: bus_next = to_nib ? lcdhi_pkg::LCDHI_BUS_HI : lcdhi_pkg::LCDHI_BUS_8BIT;
        lcdhi_pkg::LCDHI_BUS_HI:   bus_next = lcdhi_pkg::LCDHI_BUS_LO;
        lcdhi_pkg::LCDHI_BUS_LO:   bus_next = to_8bit ? lcdhi_pkg::LCDHI_BUS_8BIT : lcdhi_pkg::LCDHI_BUS_HI;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      bus_reg <= lcdhi_pkg::LCDHI_BUS_INIT;
    else
      bus_reg <= bus_next;
  end

  // upper half held until the lower half arrives
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      hi_reg <= 4'h0;
    else if (stb && bus_reg == lcdhi_pkg::LCDHI_BUS_HI)
      hi_reg <= up_n;
  end

  // text ram; shifts never write it, so contents survive shifting
  always_ff @(posedge sys_clk)
  begin
    if (wr_text)
      text_ram[addr_reg] <= byte_in;
    rd_reg <= text_ram[rd_addr];
  end

  // address, window and mode state
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      addr_reg      <= 7'h00;
      shift_reg     <= 7'h00;
      two_line_reg  <= 1'b0;
      inc_reg       <= 1'b1;
      shift_en_reg  <= 1'b0;
      glyph_sel_reg <= 1'b0;
    end
    else if (exec)
    begin
      if (rs)
      begin
        addr_reg <= next_addr;
        // with entry shift on, the window follows each written character
        if (shift_en_reg)
          shift_reg <= lcdhi_win_step(shift_reg, inc_reg, two_line_reg);
      end
      else if (is_ddaddr)
      begin
        addr_reg      <= byte_in[6:0];
        glyph_sel_reg <= 1'b0;
      end
      else if (is_cgaddr)
        glyph_sel_reg <= 1'b1;
      else if (is_fset)
        two_line_reg <= byte_in[3];
      else if (is_shift)
      begin
        if (byte_in[3])
          shift_reg <= lcdhi_win_step(shift_reg, byte_in[2], two_line_reg);
        else
          addr_reg <= lcdhi_addr_step(addr_reg, byte_in[2], two_line_reg);
      end
      else if (is_entry)
      begin
        inc_reg      <= byte_in[1];
        shift_en_reg <= byte_in[0];
      end
      else if (is_home || is_clear)
      begin
        addr_reg      <= 7'h00;
        shift_reg     <= 7'h00;
        glyph_sel_reg <= 1'b0;
      end
    end
  end

  // registered outputs
  // exec_pulse lags execution by one edge, when address and window have settled
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      exec_pulse <= 1'b0;
      nibble_out <= 1'b0;
    end
    else
    begin
      exec_pulse <= exec;
      nibble_out <= (bus_next == lcdhi_pkg::LCDHI_BUS_HI) || (bus_next == lcdhi_pkg::LCDHI_BUS_LO);
    end
  end

  // outputs taken straight from their registers
  assign rd_char      = rd_reg;
  assign addr_out     = addr_reg;
  assign shift_out    = shift_reg;
  assign two_line_out = two_line_reg;
endmodule : lcdhi_dev

// File: hw/lcdhi_regs.svh
// Purpose: constants for the display instruction link
// Assumes: 25 MHz sys_clk
// Notes:   instruction codes follow the usual character controller set
`ifndef LCDHI_REGS_SVH
`define LCDHI_REGS_SVH
`define LCDHI_RAM_DEPTH      80
`define LCDHI_LINE_LEN       40
`define LCDHI_LINE2_BASE     7'h40
`define LCDHI_FSET_NIB4      4'h2
`define LCDHI_CLK_MHZ        25
`define LCDHI_STROBE_NS      220
`define LCDHI_STROBE_CYC     ((`LCDHI_STROBE_NS * `LCDHI_CLK_MHZ + 999) / 1000)
`define LCDHI_CMD_CLEAR      8'h01
`define LCDHI_CMD_HOME       8'h02
`define LCDHI_CMD_FSET_8BIT  8'h30
`define LCDHI_CMD_FSET_4BIT  8'h28
`define LCDHI_CMD_DISP_ON    8'h0E
`define LCDHI_CMD_ENTRY      8'h06
`endif

// File: hw/lcdhi_pkg.sv
// Purpose: shared types of the display instruction link
// Assumes: constants live in lcdhi_regs.svh
// Notes:   none
package lcdhi_pkg;
  typedef enum logic [1:0]
  {
    LCDHI_BUS_INIT = 2'b00,  // first write after power-up
    LCDHI_BUS_8BIT = 2'b01,
    LCDHI_BUS_HI   = 2'b10,  // nibble mode, awaiting upper half
    LCDHI_BUS_LO   = 2'b11   // nibble mode, awaiting lower half
  } lcdhi_bus_t;
endpackage : lcdhi_pkg

// File: hw/lcdhi_link_if.sv
// Purpose: parallel write bus between host and display controller
// Assumes: one clock; strobe is a one-cycle pulse
// Notes:   host drives everything; device only listens
`timescale 1ns/1ps
interface lcdhi_link_if;
  logic       wr_stb;             // one-cycle write strobe
  logic       instr_data_select;  // 0 instruction, 1 data
  logic [7:0] data_lines;         // [7:4] are upper_nibble_lines
  modport host (output wr_stb, output instr_data_select, output data_lines);
  modport dev  (input wr_stb, input instr_data_select, input data_lines);
endinterface : lcdhi_link_if

// File: hw/lcdhi_host.sv
// Purpose: host end: power-up function set, then byte writes
// Assumes: device reset together with host
// Notes:   the NIBBLE parameter chooses 4 or 8 data lines when the host is built
`timescale 1ns/1ps
`include "lcdhi_regs.svh"
module lcdhi_host
#(
  parameter bit NIBBLE = 1'b1   // 1 uses only upper_nibble_lines
)
(
  input  wire logic       sys_clk,   // system clock
  input  wire logic       srst,      // synchronous reset, active high
  lcdhi_link_if.host      link,      // bus to the display
  input  wire logic       req_valid, // user byte request
  input  wire logic       req_rs,    // 0 instruction, 1 data
  input  wire logic [7:0] req_byte,  // byte to send
  output logic            req_ready, // request taken when high with valid
  output logic            init_done  // high once the last init byte is taken, before it is sent
);
  localparam logic [3:0] GAP = 4'(`LCDHI_STROBE_CYC);
  // init: function set, display on, entry mode (function set first)
  localparam int NINIT = 3;
  logic [7:0] init_rom [0:NINIT-1];
  assign init_rom[0] = NIBBLE ? `LCDHI_CMD_FSET_4BIT : `LCDHI_CMD_FSET_8BIT;
  assign init_rom[1] = `LCDHI_CMD_DISP_ON;
  assign init_rom[2] = `LCDHI_CMD_ENTRY;

  logic [1:0] idx_reg;     // 0 is the lone upper-half write
  logic       boot_reg;
  logic [7:0] byte_reg;
  logic       rs_reg, half_reg, busy_reg, stb_reg;
  logic [3:0] gap_reg;
  logic [7:0] dl_reg;

  wire idle      = !busy_reg && gap_reg == 4'h0;
  wire take_user = idle && !boot_reg && req_valid;
  wire take_init = idle && boot_reg;
  wire [7:0] ib  = init_rom[idx_reg == 2'd0 ? 2'd0 : idx_reg - 2'd1];

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      idx_reg  <= 2'd0;
      boot_reg <= 1'b1;
      busy_reg <= 1'b0;
      half_reg <= 1'b0;
      stb_reg  <= 1'b0;
      gap_reg  <= 4'h0;
      dl_reg   <= 8'h00;
      rs_reg   <= 1'b0;
      byte_reg <= 8'h00;
    end
    else
    begin
      stb_reg <= 1'b0;
      if (gap_reg != 4'h0)
        gap_reg <= gap_reg - 4'h1;
      if (take_init && idx_reg == 2'd0)
      begin
        // single full-width write before nibble mode exists; lower lines are unwired in nibble mode
        dl_reg  <= NIBBLE ? {ib[7:4], 4'h0} : ib;
        rs_reg  <= 1'b0;
        stb_reg <= 1'b1;
        gap_reg <= GAP;
        idx_reg <= 2'd1;
      end
      else if (take_init || take_user)
      begin
        byte_reg <= take_init ? ib : req_byte;
        rs_reg   <= take_init ? 1'b0 : req_rs;
        busy_reg <= 1'b1;
        half_reg <= 1'b0;
        if (take_init)
        begin
          if (idx_reg == 2'(NINIT)) boot_reg <= 1'b0;
          else idx_reg <= idx_reg + 2'd1;
        end
      end
      else if (busy_reg && gap_reg == 4'h0)
      begin
        // upper half first, lower half second; the same gap follows each half, so halves come one edge closer than whole bytes
        dl_reg   <= !NIBBLE ? byte_reg : (half_reg ? {byte_reg[3:0], 4'h0} : {byte_reg[7:4], 4'h0});
        stb_reg  <= 1'b1;
        gap_reg  <= GAP;
        half_reg <= 1'b1;
        busy_reg <= NIBBLE && !half_reg;
      end
    end
  end

  assign link.wr_stb            = stb_reg;
  assign link.instr_data_select = rs_reg;
  assign link.data_lines        = dl_reg;
  assign req_ready              = idle && !boot_reg;
  assign init_done              = !boot_reg;
endmodule : lcdhi_host

// File: verif/lcdhi_link_checker.sv
// Purpose: watches the link between host and display ends
// Assumes: host built for nibble transfers
// Notes:   exec latency accepted as one or two edges
`timescale 1ns/1ps
module lcdhi_link_checker
(
  input wire logic       sys_clk,           // system clock
  input wire logic       srst,              // sync reset
  input wire logic       wr_stb,            // write strobe
  input wire logic       instr_data_select, // 0 instruction
  input wire logic [7:0] data_lines,        // bus lines
  input wire logic       nibble_out,        // device 4-bit flag
  input wire logic       exec_pulse         // device execute pulse
);
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic       half_reg;
  logic       half_next;
  // strobe count saturates; halves alternate only after the lone first write
  assign cnt_next  = (wr_stb && cnt_reg != 2'h3) ? cnt_reg + 2'h1 : cnt_reg;
  assign half_next = (wr_stb && cnt_reg != 2'h0) ? !half_reg : half_reg;
  // short helper registers
  always_ff @(posedge sys_clk)
  begin
    cnt_reg  <= srst ? 2'h0 : cnt_next;
    half_reg <= srst ? 1'b0 : half_next;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_spacing; wr_stb |=> !wr_stb [*5]; endproperty
  property p_wide_start; cnt_reg == 2'h0 |-> !nibble_out; endproperty
  property p_first_full; wr_stb && cnt_reg == 2'h0 |-> data_lines == 8'h20 && !instr_data_select; endproperty
  property p_first_exec; wr_stb && cnt_reg == 2'h0 |-> ##[1:2] exec_pulse; endproperty
  property p_enter_nibble; wr_stb && cnt_reg == 2'h0 |-> ##2 nibble_out; endproperty
  property p_refset; wr_stb && cnt_reg == 2'h1 |-> data_lines[7:4] == 4'h2; endproperty
  property p_upper_first; wr_stb && cnt_reg == 2'h2 |-> data_lines[7:4] == 4'h8; endproperty
  property p_half_quiet; wr_stb && cnt_reg != 2'h0 && !half_reg |=> !exec_pulse [*5]; endproperty
  property p_pair_exec; wr_stb && half_reg |-> ##[1:2] exec_pulse; endproperty
  a_spacing: assert property (p_spacing) else $error("strobes too close");
  a_wide_start: assert property (p_wide_start) else $error("nibble mode before any write");
  a_first_full: assert property (p_first_full) else $error("first write not function set");
  a_first_exec: assert property (p_first_exec) else $error("first write not executed whole");
  a_enter_nibble: assert property (p_enter_nibble) else $error("nibble mode not entered");
  a_refset: assert property (p_refset) else $error("function set upper half not repeated");
  a_upper_first: assert property (p_upper_first) else $error("lower half sent first");
  a_half_quiet: assert property (p_half_quiet) else $error("executed on first half");
  a_pair_exec: assert property (p_pair_exec) else $error("pair not executed");
  c_pair: cover property (wr_stb && half_reg);
  c_nibble: cover property ($rose(nibble_out));
  c_exec: cover property (exec_pulse);
endmodule : lcdhi_link_checker

// File: verif/lcd_host_instruction_init_test.sv
// Purpose: bench for host and display ends joined by the link
// Assumes: nibble host; 25 MHz clock
// Notes:   user bytes enter through the host request port
`timescale 1ns/1ps
module lcd_host_instruction_init_test;
  logic       sys_clk;      // clock
  logic       srst;         // reset
  logic       req_valid;    // request
  logic       req_rs;       // 1 data
  logic [7:0] req_byte;     // byte
  logic       req_ready;    // host ready
  logic       init_done;    // init finished
  logic [6:0] rd_addr;      // ram peek address
  logic [7:0] rd_char;      // ram peek data
  logic [6:0] addr_out;     // ram address
  logic [6:0] shift_out;    // window offset
  logic       two_line_out; // two lines
  logic       nibble_out;   // 4-bit mode
  logic       exec_pulse;   // executed
  int         fails;
  int         checks;
  lcdhi_link_if lcdhi_link_if_inst ();
  lcdhi_host #(.NIBBLE(1'b1)) lcdhi_host_inst (.sys_clk(sys_clk), .srst(srst), .link(lcdhi_link_if_inst),
    .req_valid(req_valid), .req_rs(req_rs), .req_byte(req_byte), .req_ready(req_ready), .init_done(init_done));
  lcdhi_dev lcdhi_dev_inst (.sys_clk(sys_clk), .srst(srst), .link(lcdhi_link_if_inst), .rd_addr(rd_addr),
    .rd_char(rd_char), .addr_out(addr_out), .shift_out(shift_out), .two_line_out(two_line_out),
    .nibble_out(nibble_out), .exec_pulse(exec_pulse));
  lcdhi_link_checker lcdhi_link_checker_inst (.sys_clk(sys_clk), .srst(srst), .wr_stb(lcdhi_link_if_inst.wr_stb),
    .instr_data_select(lcdhi_link_if_inst.instr_data_select), .data_lines(lcdhi_link_if_inst.data_lines),
    .nibble_out(nibble_out), .exec_pulse(exec_pulse));
  // free-running clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // bounded wait at falling edges: 0 ready, 1 exec, 2 init
  task automatic wait_hi(input int which);
    int n;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end while (((which == 0) ? req_ready : (which == 1) ? exec_pulse : init_done) !== 1'b1 && n < 400);
    if (n >= 400)
    begin
      fails++;
      $display("MISMATCH t=%0t wait %0d timed out", $time, which);
      report_and_stop();
    end
  endtask : wait_hi
  // one byte through the host, then wait until the device executes it
  task automatic send(input logic rs, input logic [7:0] b);
    wait_hi(0);
    req_valid = 1'b1;
    req_rs = rs;
    req_byte = b;
    @(negedge sys_clk);
    req_valid = 1'b0;
    wait_hi(1);
  endtask : send
  // peek port has one cycle of latency
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    rd_addr = a;
    @(negedge sys_clk);
    @(negedge sys_clk);
    chk(rd_char, exp);
  endtask : rd
  // main sequence
  initial
  begin
    srst = 1'b1;
    req_valid = 1'b0;
    req_rs = 1'b0;
    req_byte = 8'h00;
    rd_addr = 7'h00;
    fails = 0;
    checks = 0;
    repeat (10) @(negedge sys_clk);
    srst = 1'b0;
    chk({7'h00, nibble_out}, 8'h00);
    wait_hi(2);
    chk({7'h00, nibble_out}, 8'h01);
    chk({7'h00, two_line_out}, 8'h01);
    $display("test init done");
    send(1'b1, 8'h50);
    rd(7'h00, 8'h50);
    chk({1'b0, addr_out}, 8'h01);
    $display("test first data done");
    send(1'b0, 8'hA7);
    send(1'b1, 8'h41);
    chk({1'b0, addr_out}, 8'h40);
    send(1'b1, 8'h42);
    rd(7'h27, 8'h41);
    rd(7'h40, 8'h42);
    send(1'b0, 8'hE7);
    send(1'b1, 8'h43);
    rd(7'h67, 8'h43);
    $display("test wrap done");
    send(1'b0, 8'h1C);
    chk({7'h00, shift_out != 7'h00}, 8'h01);
    rd(7'h00, 8'h50);
    rd(7'h40, 8'h42);
    send(1'b0, 8'h18);
    send(1'b0, 8'h18);
    chk({1'b0, shift_out}, 8'h27);
    send(1'b0, 8'h02);
    chk({1'b0, shift_out}, 8'h00);
    chk({1'b0, addr_out}, 8'h00);
    $display("test shift and home done");
    report_and_stop();
  end
endmodule : lcd_host_instruction_init_test
